// ==== hdl/dewg_top.sv ====
// Data EEPROM write guard: AXI4-Lite registers, unlock sequence, timers and byte array
// Summary of operation
// - Reset clears write-allow bit.
// - No write start while power-up timer runs.
// - Write needs write-allow plus 55h then AAh.
// - Unlocked write-start programs addressed byte.
// - Write-start reads set until write completes.
// - Code protect refuses external reads and writes.
// - Core access ignores code protect.
// - One byte per access; core at pointer, external port at ext_addr_in.
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module dewg_top #(
	parameter int unsigned PWRT_CYCLES  = dewg_pkg::PWRT_CYCLES,
	parameter int unsigned WRITE_CYCLES = dewg_pkg::WRITE_CYCLES
) (
	input  wire logic       clk_in,
	input  wire logic       sys_rst_in,
	input  wire logic       s_axi_awvalid_in,
	output logic            s_axi_awready_out,
	input  wire logic [7:0] s_axi_awaddr_in,
	input  wire logic       s_axi_wvalid_in,
	output logic            s_axi_wready_out,
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0] s_axi_wstrb_in,
	output logic            s_axi_bvalid_out,
	input  wire logic       s_axi_bready_in,
	output logic [1:0]      s_axi_bresp_out,
	input  wire logic       s_axi_arvalid_in,
	output logic            s_axi_arready_out,
	input  wire logic [7:0] s_axi_araddr_in,
	output logic            s_axi_rvalid_out,
	input  wire logic       s_axi_rready_in,
	output logic [31:0]     s_axi_rdata_out,
	output logic [1:0]      s_axi_rresp_out,
	input  wire logic       ext_req_in,
	input  wire logic       ext_we_in,
	input  wire logic [7:0] ext_addr_in,
	input  wire logic [7:0] ext_wdata_in,
	output logic            ext_ack_out,
	output logic            ext_refused_out,
	output logic [7:0]      ext_rdata_out
);
	localparam logic [23:0] PWRT_LOAD  = 24'(PWRT_CYCLES - 1);
	localparam logic [23:0] WRITE_LOAD = 24'(WRITE_CYCLES - 1);

	// Byte array; one byte per location
	logic [7:0] mem_q [dewg_pkg::DEPTH];

	// Bus channel state
	logic awready_q, awready_d, aw_full_q, aw_full_d;
	logic wready_q, wready_d, w_full_q, w_full_d;
	logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [7:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
	logic [3:0] wstrb_q, wstrb_d;

	// Block state
	logic write_allow_q, write_allow_d, array_select_q, array_select_d;
	logic config_space_select_q, config_space_select_d;
	logic protect_q, protect_d, busy_q, busy_d, ignored_q, ignored_d;
	logic pwrt_run_q, pwrt_run_d;
	logic [23:0] pwrt_cnt_q, pwrt_cnt_d, wr_cnt_q, wr_cnt_d;
	logic [7:0] nvm_byte_pointer_q, nvm_byte_pointer_d, data_q, data_d;
	logic [7:0] wr_addr_q, wr_addr_d, wr_byte_q, wr_byte_d;
	dewg_pkg::dewg_key_t key_q, key_d;
	logic ext_ack_q, ext_ack_d, ext_refused_q, ext_refused_d;
	logic [7:0] ext_rdata_q, ext_rdata_d;

	// Array write port
	logic       mem_we;
	logic [7:0] mem_waddr, mem_wbyte;

	logic       do_wr, lane0, data_space;
	logic [7:0] read_byte;

	// Register read mux; unmapped offsets answer zero with an error response
	always_comb begin
		read_byte = dewg_pkg::RST_BYTE;
		rresp_d   = dewg_pkg::RESP_OKAY;
		case (s_axi_araddr_in)
			dewg_pkg::OFS_NVM_CONTROL: begin
				read_byte[dewg_pkg::CTL_WRITE_START_BIT] = busy_q;
				read_byte[dewg_pkg::CTL_WRITE_ALLOW_BIT] = write_allow_q;
				read_byte[dewg_pkg::CTL_CFG_SPACE_BIT]   = config_space_select_q;
				read_byte[dewg_pkg::CTL_ARRAY_SEL_BIT]   = array_select_q;
			end
			dewg_pkg::OFS_BYTE_POINTER: read_byte = nvm_byte_pointer_q;
			dewg_pkg::OFS_DATA:         read_byte = data_q;
			dewg_pkg::OFS_UNLOCK_KEY:   read_byte = dewg_pkg::RST_BYTE;
			dewg_pkg::OFS_STATUS: begin
				read_byte[dewg_pkg::STS_PWRT_BIT]    = pwrt_run_q;
				read_byte[dewg_pkg::STS_ARMED_BIT]   = (key_q == dewg_pkg::KEY_ARMED);
				read_byte[dewg_pkg::STS_BUSY_BIT]    = busy_q;
				read_byte[dewg_pkg::STS_IGNORED_BIT] = ignored_q;
			end
			dewg_pkg::OFS_CONFIG: read_byte[dewg_pkg::CFG_PROTECT_BIT] = protect_q;
			default: rresp_d = dewg_pkg::RESP_SLVERR;
		endcase
	end

	// Next-state logic for bus, unlock sequence, timers and external port
	always_comb begin
		awready_d = awready_q;
		aw_full_d = aw_full_q;
		awaddr_d  = awaddr_q;
		wready_d  = wready_q;
		w_full_d  = w_full_q;
		wdata_d   = wdata_q;
		wstrb_d   = wstrb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		arready_d = arready_q;
		rvalid_d  = rvalid_q;
		rdata_d   = rdata_q;
		write_allow_d         = write_allow_q;
		array_select_d        = array_select_q;
		config_space_select_d = config_space_select_q;
		protect_d             = protect_q;
		busy_d                = busy_q;
		ignored_d             = ignored_q;
		pwrt_run_d            = pwrt_run_q;
		pwrt_cnt_d            = pwrt_cnt_q;
		wr_cnt_d              = wr_cnt_q;
		nvm_byte_pointer_d    = nvm_byte_pointer_q;
		data_d                = data_q;
		wr_addr_d             = wr_addr_q;
		wr_byte_d             = wr_byte_q;
		key_d                 = key_q;
		ext_ack_d             = 1'b0;
		ext_refused_d         = 1'b0;
		ext_rdata_d           = ext_rdata_q;
		mem_we    = 1'b0;
		mem_waddr = wr_addr_q;
		mem_wbyte = wr_byte_q;
		do_wr      = aw_full_q && w_full_q && !bvalid_q;
		lane0      = wstrb_q[0];
		data_space = !array_select_q && !config_space_select_q;

		// Power-up timer holds off write starts after every reset; the external port can still write
		if (pwrt_run_q) begin
			if (pwrt_cnt_q == 24'h000000) begin
				pwrt_run_d = 1'b0;
			end else begin
				pwrt_cnt_d = pwrt_cnt_q - 24'h000001;
			end
		end

		// Write cycle timer; the byte lands when it expires
		if (busy_q) begin
			if (wr_cnt_q == 24'h000000) begin
				busy_d = 1'b0;
				mem_we = 1'b1;
			end else begin
				wr_cnt_d = wr_cnt_q - 24'h000001;
			end
		end

		// Address and data channels are taken independently, in either order
		if (s_axi_awvalid_in && awready_q) begin
			aw_full_d = 1'b1;
			awaddr_d  = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && wready_q) begin
			w_full_d = 1'b1;
			wdata_d  = s_axi_wdata_in;
			wstrb_d  = s_axi_wstrb_in;
		end
		if (bvalid_q && s_axi_bready_in) begin
			bvalid_d = 1'b0;
		end

		// Register write once both halves are present
		if (do_wr) begin
			aw_full_d = 1'b0;
			w_full_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = dewg_pkg::RESP_OKAY;
			case (awaddr_q)
				dewg_pkg::OFS_NVM_CONTROL: if (lane0) begin
					write_allow_d         = wdata_q[dewg_pkg::CTL_WRITE_ALLOW_BIT];
					array_select_d        = wdata_q[dewg_pkg::CTL_ARRAY_SEL_BIT];
					config_space_select_d = wdata_q[dewg_pkg::CTL_CFG_SPACE_BIT];
					// Any control write consumes the unlock, used or not
					key_d = dewg_pkg::KEY_IDLE;
					if (wdata_q[dewg_pkg::CTL_READ_BIT] && data_space) begin
						data_d = mem_q[nvm_byte_pointer_q];
					end
					if (wdata_q[dewg_pkg::CTL_WRITE_START_BIT] && !busy_q) begin
						if (key_q == dewg_pkg::KEY_ARMED && write_allow_q && !pwrt_run_q
							&& data_space) begin
							busy_d    = 1'b1;
							wr_cnt_d  = WRITE_LOAD;
							wr_addr_d = nvm_byte_pointer_q;
							wr_byte_d = data_q;
							ignored_d = 1'b0;
						end else begin
							ignored_d = 1'b1;
						end
					end
				end
				dewg_pkg::OFS_BYTE_POINTER: if (lane0) begin
					nvm_byte_pointer_d = wdata_q[7:0];
				end
				dewg_pkg::OFS_DATA: if (lane0) begin
					data_d = wdata_q[7:0];
				end
				dewg_pkg::OFS_UNLOCK_KEY: if (lane0) begin
					// Only the exact pair in order arms; anything else starts over
					if (wdata_q[7:0] == dewg_pkg::KEY_FIRST) begin
						key_d = dewg_pkg::KEY_HALF;
					end else if (wdata_q[7:0] == dewg_pkg::KEY_SECOND && key_q == dewg_pkg::KEY_HALF) begin
						key_d = dewg_pkg::KEY_ARMED;
					end else begin
						key_d = dewg_pkg::KEY_IDLE;
					end
				end
				dewg_pkg::OFS_STATUS: ;
				dewg_pkg::OFS_CONFIG: if (lane0) begin
					protect_d = wdata_q[dewg_pkg::CFG_PROTECT_BIT];
				end
				default: bresp_d = dewg_pkg::RESP_SLVERR;
			endcase
		end
		awready_d = !aw_full_d && !bvalid_d;
		wready_d  = !w_full_d && !bvalid_d;

		// Read channel: one outstanding read
		if (rvalid_q && s_axi_rready_in) begin
			rvalid_d  = 1'b0;
			arready_d = 1'b1;
		end
		if (s_axi_arvalid_in && arready_q) begin
			arready_d = 1'b0;
			rvalid_d  = 1'b1;
			rdata_d   = {24'h000000, read_byte};
		end

		// External programming port waits while an internal write is in flight
		if (ext_req_in && !busy_q && !ext_ack_q && !ext_refused_q) begin
			if (protect_q) begin
				ext_refused_d = 1'b1;
			end else begin
				ext_ack_d = 1'b1;
				if (ext_we_in) begin
					mem_we    = 1'b1;
					mem_waddr = ext_addr_in;
					mem_wbyte = ext_wdata_in;
				end else begin
					ext_rdata_d = mem_q[ext_addr_in];
				end
			end
		end
	end

	// Array storage; internal writes take priority through the busy stall above
	always_ff @(posedge clk_in) begin
		if (mem_we) begin
			mem_q[mem_waddr] <= mem_wbyte;
		end
	end

	// State registers
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			awready_q             <= 1'b1;
			aw_full_q             <= 1'b0;
			awaddr_q              <= dewg_pkg::RST_BYTE;
			wready_q              <= 1'b1;
			w_full_q              <= 1'b0;
			wdata_q               <= 32'h00000000;
			wstrb_q               <= 4'h0;
			bvalid_q              <= 1'b0;
			bresp_q               <= dewg_pkg::RESP_OKAY;
			arready_q             <= 1'b1;
			rvalid_q              <= 1'b0;
			rresp_q               <= dewg_pkg::RESP_OKAY;
			rdata_q               <= 32'h00000000;
			write_allow_q         <= 1'b0;
			array_select_q        <= 1'b0;
			config_space_select_q <= 1'b0;
			protect_q             <= 1'b0;
			busy_q                <= 1'b0;
			ignored_q             <= 1'b0;
			pwrt_run_q            <= 1'b1;
			pwrt_cnt_q            <= PWRT_LOAD;
			wr_cnt_q              <= 24'h000000;
			nvm_byte_pointer_q    <= dewg_pkg::RST_BYTE;
			data_q                <= dewg_pkg::RST_BYTE;
			wr_addr_q             <= dewg_pkg::RST_BYTE;
			wr_byte_q             <= dewg_pkg::RST_BYTE;
			key_q                 <= dewg_pkg::KEY_IDLE;
			ext_ack_q             <= 1'b0;
			ext_refused_q         <= 1'b0;
			ext_rdata_q           <= dewg_pkg::RST_BYTE;
		end else begin
			awready_q             <= awready_d;
			aw_full_q             <= aw_full_d;
			awaddr_q              <= awaddr_d;
			wready_q              <= wready_d;
			w_full_q              <= w_full_d;
			wdata_q               <= wdata_d;
			wstrb_q               <= wstrb_d;
			bvalid_q              <= bvalid_d;
			bresp_q               <= bresp_d;
			arready_q             <= arready_d;
			rvalid_q              <= rvalid_d;
			if (s_axi_arvalid_in && arready_q) begin
				rresp_q <= rresp_d;
			end
			rdata_q               <= rdata_d;
			write_allow_q         <= write_allow_d;
			array_select_q        <= array_select_d;
			config_space_select_q <= config_space_select_d;
			protect_q             <= protect_d;
			busy_q                <= busy_d;
			ignored_q             <= ignored_d;
			pwrt_run_q            <= pwrt_run_d;
			pwrt_cnt_q            <= pwrt_cnt_d;
			wr_cnt_q              <= wr_cnt_d;
			nvm_byte_pointer_q    <= nvm_byte_pointer_d;
			data_q                <= data_d;
			wr_addr_q             <= wr_addr_d;
			wr_byte_q             <= wr_byte_d;
			key_q                 <= key_d;
			ext_ack_q             <= ext_ack_d;
			ext_refused_q         <= ext_refused_d;
			ext_rdata_q           <= ext_rdata_d;
		end
	end

	// All outputs straight from flops
	assign s_axi_awready_out = awready_q;
	assign s_axi_wready_out  = wready_q;
	assign s_axi_bvalid_out  = bvalid_q;
	assign s_axi_bresp_out   = bresp_q;
	assign s_axi_arready_out = arready_q;
	assign s_axi_rvalid_out  = rvalid_q;
	assign s_axi_rdata_out   = rdata_q;
	assign s_axi_rresp_out   = rresp_q;
	assign ext_ack_out       = ext_ack_q;
	assign ext_refused_out   = ext_refused_q;
	assign ext_rdata_out     = ext_rdata_q;
endmodule : dewg_top
`default_nettype wire

// ==== hdl/dewg_pkg.sv ====
// Package holding the register map, field positions and timing constants of the write guard
package dewg_pkg;
	// Bus geometry
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned BYTE_W = 8;
	localparam int unsigned DEPTH  = 256;

	// Register byte offsets
	localparam logic [7:0] OFS_NVM_CONTROL  = 8'h00;
	localparam logic [7:0] OFS_BYTE_POINTER = 8'h04;
	localparam logic [7:0] OFS_DATA         = 8'h08;
	localparam logic [7:0] OFS_UNLOCK_KEY   = 8'h0c;
	localparam logic [7:0] OFS_STATUS       = 8'h10;
	localparam logic [7:0] OFS_CONFIG       = 8'h14;

	// Control register fields
	localparam int unsigned CTL_READ_BIT        = 0;
	localparam int unsigned CTL_WRITE_START_BIT = 1;
	localparam int unsigned CTL_WRITE_ALLOW_BIT = 2;
	localparam int unsigned CTL_CFG_SPACE_BIT   = 6;
	localparam int unsigned CTL_ARRAY_SEL_BIT   = 7;

	// Status register fields (read only)
	localparam int unsigned STS_PWRT_BIT    = 0;
	localparam int unsigned STS_ARMED_BIT   = 1;
	localparam int unsigned STS_BUSY_BIT    = 2;
	localparam int unsigned STS_IGNORED_BIT = 3;

	// Config register field
	localparam int unsigned CFG_PROTECT_BIT = 0;

	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;

	// Unlock key values
	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Timing
	localparam int unsigned CLK_MHZ        = 100;
	localparam int unsigned PWRT_TIME_MS   = 72;
	localparam int unsigned WRITE_TIME_US  = 4000;
	localparam int unsigned PWRT_CYCLES    = PWRT_TIME_MS * 1000 * CLK_MHZ;
	localparam int unsigned WRITE_CYCLES   = WRITE_TIME_US * CLK_MHZ;
	localparam int unsigned CNT_W          = 24;

	// Unlock sequence states
	typedef enum logic [2:0] {
		KEY_IDLE  = 3'b001,
		KEY_HALF  = 3'b010,
		KEY_ARMED = 3'b100
	} dewg_key_t;
endpackage : dewg_pkg

// ==== verif/dewg_assertions.sv ====
// Checker of bus and side-port timing of the write guard
`timescale 1ns/100ps
`default_nettype none
module dewg_assertions (
	input wire logic        clk_in,
	input wire logic        sys_rst_in,
	input wire logic        s_axi_awvalid_in,
	input wire logic        s_axi_awready_out,
	input wire logic        s_axi_wvalid_in,
	input wire logic        s_axi_wready_out,
	input wire logic        s_axi_bvalid_out,
	input wire logic        s_axi_bready_in,
	input wire logic [1:0]  s_axi_bresp_out,
	input wire logic        s_axi_arvalid_in,
	input wire logic        s_axi_arready_out,
	input wire logic        s_axi_rvalid_out,
	input wire logic        s_axi_rready_in,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic        ext_req_in,
	input wire logic        ext_ack_out,
	input wire logic        ext_refused_out
);
	// One clock domain, so clock and reset are given once
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	// Bus answers with their fixed latencies, held until taken
	AST_B_LAT: assert property (
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
		|=> !s_axi_bvalid_out ##1 s_axi_bvalid_out) else $error("write answer late");
	AST_B_HOLD: assert property (
		s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
		else $error("write answer dropped");
	AST_AW_BLK: assert property (
		s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
		else $error("write taken while answer pending");
	AST_R_LAT: assert property (
		s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out) else $error("read late");
	AST_R_HOLD: assert property (
		s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
		else $error("read data dropped");
	// Side port answers are single pulses caused by a request
	AST_ACK_ONE: assert property (
		ext_ack_out |=> !ext_ack_out && !ext_refused_out) else $error("ack too long");
	AST_ANS_CAUSE: assert property (
		ext_ack_out || ext_refused_out |-> $past(ext_req_in)) else $error("answer unasked");
	AST_EXCL: assert property (
		!(ext_ack_out && ext_refused_out)) else $error("ack and refusal together");

	// Main scenarios reached
	COV_REF: cover property (ext_refused_out);
	COV_ACK: cover property (ext_ack_out);
	COV_ERR: cover property (s_axi_bvalid_out && s_axi_bresp_out == 2'h2);
endmodule : dewg_assertions

bind dewg_top dewg_assertions chk_u (.clk_in, .sys_rst_in, .s_axi_awvalid_in,
	.s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out,
	.s_axi_bready_in, .s_axi_bresp_out, .s_axi_arvalid_in, .s_axi_arready_out,
	.s_axi_rvalid_out, .s_axi_rready_in, .s_axi_rdata_out, .ext_req_in, .ext_ack_out,
	.ext_refused_out);
`default_nettype wire

// ==== verif/dewg_ext_prog.sv ====
// Model of the external programmer on the side port
`timescale 1ns/100ps
`default_nettype none
module dewg_ext_prog (
	input wire logic       clk_in,
	input wire logic       ack_in,
	input wire logic       refused_in,
	input wire logic [7:0] rdata_in,
	output logic           req_out,
	output logic           we_out,
	output logic [7:0]     addr_out,
	output logic [7:0]     wdata_out
);
	// Idle at time zero
	initial begin
		req_out = 1'b0;
		we_out = 1'b0;
		addr_out = 8'h00;
		wdata_out = 8'h00;
	end

	// One byte per access, held until answered; a slow caller passes a wait
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input int dly,
		output logic [7:0] q, output logic rf);
		repeat (dly) @(posedge clk_in);
		req_out <= 1'b1;
		we_out <= w;
		addr_out <= a;
		wdata_out <= d;
		do @(posedge clk_in); while (!(ack_in || refused_in));
		q = rdata_in;
		rf = refused_in;
		req_out <= 1'b0;
		addr_out <= ~a; // Released lines must not keep a stale value
		wdata_out <= ~d;
	endtask : acc
endmodule : dewg_ext_prog
`default_nettype wire

// ==== verif/dewg_tb_top.sv ====
// Self-checking bench of the data EEPROM write guard
`timescale 1ns/100ps
`default_nettype none
module dewg_tb_top;
	localparam logic [7:0] CT = dewg_pkg::OFS_NVM_CONTROL;
	localparam logic [7:0] DT = dewg_pkg::OFS_DATA;
	localparam logic [7:0] KY = dewg_pkg::OFS_UNLOCK_KEY;
	localparam logic [7:0] ST = dewg_pkg::OFS_STATUS;
	localparam logic [7:0] CF = dewg_pkg::OFS_CONFIG;
	// Bus, side port and bench state
	logic        clk_in, sys_rst_in, awv, wv, bry, arv, rry, aw_rdy, w_rdy, b_vld, ar_rdy;
	logic        r_vld, e_req, e_we, e_ack, e_ref, rf;
	logic [1:0]  b_resp, r_resp, rs;
	logic [7:0]  awa, ara, e_addr, e_wd, e_rd, a, eq;
	logic [31:0] wd, r_data, q, d, c;
	int          error_cnt, n_tests, seed;

	dewg_top #(.PWRT_CYCLES(50), .WRITE_CYCLES(20)) dut_u (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.s_axi_awvalid_in(awv), .s_axi_awready_out(aw_rdy), .s_axi_awaddr_in(awa),
		.s_axi_wvalid_in(wv), .s_axi_wready_out(w_rdy), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'h1),
		.s_axi_bvalid_out(b_vld), .s_axi_bready_in(bry), .s_axi_bresp_out(b_resp),
		.s_axi_arvalid_in(arv), .s_axi_arready_out(ar_rdy), .s_axi_araddr_in(ara),
		.s_axi_rvalid_out(r_vld), .s_axi_rready_in(rry), .s_axi_rdata_out(r_data),
		.s_axi_rresp_out(r_resp), .ext_req_in(e_req), .ext_we_in(e_we), .ext_addr_in(e_addr),
		.ext_wdata_in(e_wd), .ext_ack_out(e_ack), .ext_refused_out(e_ref), .ext_rdata_out(e_rd));
	dewg_ext_prog pe_u (.clk_in(clk_in), .ack_in(e_ack), .refused_in(e_ref), .rdata_in(e_rd),
		.req_out(e_req), .we_out(e_we), .addr_out(e_addr), .wdata_out(e_wd));

	// 100 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	// Cuts a hang short; the full run needs far less than this
	initial begin
		#100us;
		error_cnt++;
		end_sim;
	end

	function automatic logic [31:0] st_exp(input logic p, input logic ar, input logic bz,
		input logic ig);
		return {28'h0, ig, bz, ar, p};
	endfunction : st_exp

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_sim

	// Address and data offered together; answer taken late so the slave must hold it
	task automatic wr(input logic [7:0] ad, input logic [31:0] dv, input logic [1:0] er = 2'h0);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		awa <= ad;
		wd <= dv;
		awv <= 1'b1;
		wv <= 1'b1;
		do begin
			@(posedge clk_in);
			ta = ta | aw_rdy;
			tw = tw | w_rdy;
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
		end while (!(ta && tw));
		repeat (3) @(posedge clk_in);
		bry <= 1'b1;
		do @(posedge clk_in); while (!b_vld);
		chk("bresp", {30'h0, er}, {30'h0, b_resp});
		bry <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] ad, output logic [31:0] qv, output logic [1:0] rv);
		ara <= ad;
		arv <= 1'b1;
		do @(posedge clk_in); while (!ar_rdy);
		arv <= 1'b0;
		repeat (2) @(posedge clk_in);
		rry <= 1'b1;
		do @(posedge clk_in); while (!r_vld);
		qv = r_data;
		rv = r_resp;
		rry <= 1'b0;
	endtask : rd

	// Control write, optional key pair (swapped on request), then write-start
	task automatic arm(input logic [31:0] cv, input logic keys, input logic sw);
		wr(CT, cv);
		if (keys) begin
			wr(KY, {24'h0, sw ? dewg_pkg::KEY_SECOND : dewg_pkg::KEY_FIRST});
			wr(KY, {24'h0, sw ? dewg_pkg::KEY_FIRST : dewg_pkg::KEY_SECOND});
		end
		wr(CT, cv | 32'h2);
	endtask : arm

	task automatic readback(input logic [31:0] e);
		wr(CT, 32'h1);
		rd(DT, q, rs);
		chk("data", e, q);
	endtask : readback

	// Main sequence: lockouts, good writes, each refusal kind, protection, unmapped
	initial begin
		seed = 32'h68d57a95;
		{awv, wv, bry, arv, rry} = 5'h0;
		awa = 8'h00;
		ara = 8'h00;
		wd = 32'h0;
		error_cnt = 0;
		n_tests = 0;
		sys_rst_in = 1'b1;
		repeat (16) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		rd(CT, q, rs);
		chk("ctl", 32'h0, q);
		arm(32'h4, 1'b1, 1'b0);
		rd(ST, q, rs);
		chk("sts", st_exp(1'b1, 1'b0, 1'b0, 1'b1), q);
		do rd(ST, q, rs); while (q[0]);
		// Half a key pair must not arm; the full pair must show armed
		wr(KY, {24'h0, dewg_pkg::KEY_FIRST});
		rd(ST, q, rs);
		chk("sts", st_exp(1'b0, 1'b0, 1'b0, 1'b1), q);
		wr(KY, {24'h0, dewg_pkg::KEY_SECOND});
		rd(ST, q, rs);
		chk("sts", st_exp(1'b0, 1'b1, 1'b0, 1'b1), q);
		for (int k = 0; k < 5; k++) begin
			a = (k == 0) ? 8'hff : 8'($random(seed));
			d = {24'h0, 8'($random(seed))};
			wr(dewg_pkg::OFS_BYTE_POINTER, {24'h0, a});
			wr(DT, d);
			arm(32'h4, 1'b1, 1'b0);
			rd(CT, q, rs);
			chk("ctl", 32'h6, q);
			rd(ST, q, rs);
			chk("sts", st_exp(1'b0, 1'b0, 1'b1, 1'b0), q);
			do rd(CT, q, rs); while (q[1]);
			readback(d);
			pe_u.acc(1'b0, a, 8'h00, k, eq, rf);
			chk("ext", d, {24'h0, eq});
			wr(DT, {24'h0, ~d[7:0]});
			c = (k == 2) ? 32'h0 : (k == 3) ? 32'h84 : (k == 4) ? 32'h44 : 32'h4;
			arm(c, k != 0, k == 1);
			rd(ST, q, rs);
			chk("sts", st_exp(1'b0, 1'b0, 1'b0, 1'b1), q);
			wr(CT, 32'h0);
			readback(d);
		end
		wr(CF, 32'h1);
		pe_u.acc(1'b0, a, 8'h00, 2, eq, rf);
		chk("refused", 32'h1, {31'h0, rf});
		pe_u.acc(1'b1, a, 8'h5a, 1, eq, rf);
		chk("refused", 32'h1, {31'h0, rf});
		readback(d);
		// Core write must still land while external access is locked out
		wr(DT, {24'h0, ~d[7:0]});
		arm(32'h4, 1'b1, 1'b0);
		do rd(CT, q, rs); while (q[1]);
		readback({24'h0, ~d[7:0]});
		wr(CF, 32'h0);
		pe_u.acc(1'b1, a, 8'h5a, 1, eq, rf);
		chk("refused", 32'h0, {31'h0, rf});
		readback(32'h5a);
		wr(8'h18, 32'h1, dewg_pkg::RESP_SLVERR);
		rd(8'h18, q, rs);
		chk("rresp", {30'h0, dewg_pkg::RESP_SLVERR}, {30'h0, rs});
		chk("rdata", 32'h0, q);
		// Reset again with writes allowed; the lock and the timer must come back
		wr(CT, 32'h4);
		rd(CT, q, rs);
		chk("ctl", 32'h4, q);
		sys_rst_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		rd(CT, q, rs);
		chk("ctl", 32'h0, q);
		rd(ST, q, rs);
		chk("sts", st_exp(1'b1, 1'b0, 1'b0, 1'b0), q);
		end_sim;
	end
endmodule : dewg_tb_top
`default_nettype wire
